// >>> src/rsg_profile.sv
// Ramp/soak setpoint profile generator: four ramp and four soak segments.
// Assumes process_value_in is synchronous and valid every cycle.
`default_nettype none

// Functional notes
// - Fixed profile of four ramps, each followed by its soak.
// - Ramp moves setpoint toward target, direction set by target position.
// - Ramp rate is units per minute, soak time is minutes.
// - Soak holds target for programmed time, then next ramp starts.
// - Segments run strictly in order until the eighth finishes.
// - After the last segment the cycle ends; output-off no returns working setpoint.
// - Fresh start or resume begins ramping from measured process value.
// - Hold freezes ramp setpoint and soak timer; resumes automatically.
// - Ramp stops while setpoint-to-process difference exceeds ramp hold band.
// - Soak timer counts only while process value is inside soak band.
// - Soak band lies below target after rising ramp, above after falling.
// - Positive deviation alarm when process exceeds reference by setting.
// - Negative deviation alarm when process falls below reference by magnitude.
// - Window alarm when process differs from reference by band or more.
// - Relative alarms evaluated only when that alarm type is selected.
// - Alarms and holdback bands do not influence each other.
// - Power loss in ramp resumes same ramp from power-on process value.
// - Power loss in soak ramps back to target, then runs remaining soak.
// - Elapsed soak time kept in non-volatile storage for resume.
// - Output-off yes holds close drive on until new cycle or disable.
// - Segment with zero rate and zero soak cuts the profile off.
// - A hold band programmed as zero is disabled.
// - End-of-profile alarm option energises third output about ten seconds.
module rsg_profile #(
    parameter int W = rsg_pkg::VAL_W,
    parameter int unsigned SEC_CYCLES = rsg_pkg::SEC_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic start_in,
    input wire logic resume_in,
    input wire logic [1:0] nv_seg_in,
    input wire logic nv_soak_in,
    input wire logic [W+5:0] nv_elapsed_in,
    input wire logic signed [W-1:0] process_value_in,
    input wire logic signed [W-1:0] working_setpoint_in,
    input wire logic [rsg_pkg::SEG_N-1:0][W-1:0] ramp_rate_in,
    input wire logic [rsg_pkg::SEG_N-1:0][W-1:0] target_in,
    input wire logic [rsg_pkg::SEG_N-1:0][W-1:0] soak_min_in,
    input wire logic [W-1:0] ramp_band_in,
    input wire logic [W-1:0] soak_band_in,
    input wire logic [1:0] alarm_type_in,
    input wire logic signed [W-1:0] alarm_value_in,
    input wire logic output_off_in,
    input wire logic alarm_eop_in,
    output logic signed [W-1:0] setpoint_out,
    output logic [1:0] segment_out,
    output logic ramping_out,
    output logic soaking_out,
    output logic hold_out,
    output logic alarm_out,
    output logic close_drive_out,
    output logic third_output_out,
    output logic profile_done_out,
    output logic [1:0] nv_seg_out,
    output logic nv_soak_out,
    output logic [W+5:0] nv_elapsed_out
);
    localparam int AW = W + 2;
    localparam int SW = W + 6;
    localparam int EW = 4;
    localparam logic [1:0] LAST_SEG = 2'(rsg_pkg::SEG_N - 1);

    rsg_core_if #(.W(W)) cif ();

    rsg_timebase #(.SEC_CYCLES(SEC_CYCLES)) u_tbase (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .tb(cif.tbase)
    );

    rsg_alarm #(.W(W)) u_alarm (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .al(cif.alm)
    );

    rsg_pkg::rsg_state_t state_r;
    logic [1:0] seg_r;
    logic signed [W-1:0] sp_r;
    logic [AW-1:0] acc_r;
    logic [SW-1:0] elapsed_r;
    logic rise_r;
    logic [EW-1:0] eop_cnt_r;

    logic signed [W-1:0] tgt;
    logic [W-1:0] rate;
    logic [W-1:0] soak;
    logic cut;
    logic signed [W:0] sp_diff;
    logic [W:0] sp_mag;
    logic ramp_hold;
    logic soak_in;
    logic [SW-1:0] soak_goal;
    logic soak_done;
    logic start_go;
    logic resume_go;
    logic end_go;
    logic at_tgt;
    logic signed [W:0] pv_x;
    logic signed [W:0] tgt_x;

    // Segment parameters are read live so edits to pending segments apply
    always_comb begin
        tgt = $signed(target_in[seg_r]);
        rate = ramp_rate_in[seg_r];
        soak = soak_min_in[seg_r];
        cut = (rate == '0) && (soak == '0);
        at_tgt = (sp_r == tgt);
        pv_x = {process_value_in[W-1], process_value_in};
        tgt_x = {tgt[W-1], tgt};
        sp_diff = $signed({sp_r[W-1], sp_r}) - pv_x;
        sp_mag = sp_diff[W] ? (W+1)'(-sp_diff) : sp_diff;
        ramp_hold = (ramp_band_in != '0) && (sp_mag > {1'b0, ramp_band_in});
        if (soak_band_in == '0)
            soak_in = 1'b1;
        else if (rise_r)
            soak_in = pv_x >= tgt_x - $signed({1'b0, soak_band_in});
        else
            soak_in = pv_x <= tgt_x + $signed({1'b0, soak_band_in});
        soak_goal = SW'(soak) * SW'(rsg_pkg::SEC_PER_MIN);
        soak_done = elapsed_r >= soak_goal;
        start_go = enable_in && start_in
                   && (state_r == rsg_pkg::RSG_IDLE || state_r == rsg_pkg::RSG_END);
        resume_go = enable_in && resume_in && !start_in && state_r == rsg_pkg::RSG_IDLE;
        end_go = enable_in && ((state_r == rsg_pkg::RSG_RAMP && cut)
                 || (state_r == rsg_pkg::RSG_SOAK && soak_done && seg_r == LAST_SEG));
    end

    // Segment sequencer
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= rsg_pkg::RSG_IDLE;
            seg_r <= '0;
        end else if (!enable_in) begin
            state_r <= rsg_pkg::RSG_IDLE;
            seg_r <= '0;
        end else if (start_go) begin
            state_r <= rsg_pkg::RSG_RAMP;
            seg_r <= '0;
        end else if (resume_go) begin
            state_r <= rsg_pkg::RSG_RAMP;
            seg_r <= nv_seg_in;
        end else begin
            case (state_r)
                rsg_pkg::RSG_RAMP: begin
                    if (cut)
                        state_r <= rsg_pkg::RSG_END;
                    else if (at_tgt)
                        state_r <= rsg_pkg::RSG_SOAK;
                end
                rsg_pkg::RSG_SOAK: begin
                    if (soak_done) begin
                        if (seg_r == LAST_SEG) begin
                            state_r <= rsg_pkg::RSG_END;
                        end else begin
                            state_r <= rsg_pkg::RSG_RAMP;
                            seg_r <= seg_r + 2'h1;
                        end
                    end
                end
                rsg_pkg::RSG_IDLE: state_r <= rsg_pkg::RSG_IDLE;
                rsg_pkg::RSG_END: state_r <= rsg_pkg::RSG_END;
                default: state_r <= rsg_pkg::RSG_IDLE;
            endcase
        end
    end

    // Setpoint ramp unit; whole-unit steps drain a per-second rate accumulator
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sp_r <= '0;
            acc_r <= '0;
            rise_r <= 1'b1;
        end else if (start_go || resume_go) begin
            sp_r <= process_value_in;
            acc_r <= '0;
        end else if (state_r == rsg_pkg::RSG_RAMP && !cut && !at_tgt) begin
            rise_r <= tgt > sp_r;
            // A rate-0 jump is still ramping, so holdback gates it too
            if (!ramp_hold) begin
                if (rate == '0) begin
                    sp_r <= tgt;
                end else if (cif.sec_tick) begin
                    acc_r <= acc_r + AW'(rate);
                end else if (acc_r >= AW'(rsg_pkg::SEC_PER_MIN)) begin
                    acc_r <= acc_r - AW'(rsg_pkg::SEC_PER_MIN);
                    sp_r <= (tgt > sp_r) ? sp_r + W'(1'b1) : sp_r - W'(1'b1);
                end
            end
        end else if (state_r != rsg_pkg::RSG_RAMP) begin
            acc_r <= '0;
        end
    end

    // Soak timer in seconds; survives the catch-up ramp after a resume
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            elapsed_r <= '0;
        end else if (start_go) begin
            elapsed_r <= '0;
        end else if (resume_go) begin
            elapsed_r <= nv_soak_in ? nv_elapsed_in : '0;
        end else if (state_r == rsg_pkg::RSG_SOAK) begin
            if (soak_done)
                elapsed_r <= '0;
            else if (cif.sec_tick && soak_in)
                elapsed_r <= elapsed_r + SW'(1'b1);
        end
    end

    // End-of-profile third output, counted in seconds
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            eop_cnt_r <= '0;
            third_output_out <= 1'b0;
        end else if (end_go && alarm_eop_in) begin
            eop_cnt_r <= EW'(rsg_pkg::EOP_PULSE_S);
            third_output_out <= 1'b1;
        end else if (third_output_out && cif.sec_tick) begin
            eop_cnt_r <= eop_cnt_r - EW'(1'b1);
            third_output_out <= eop_cnt_r != EW'(1'b1);
        end
    end

    // Alarm reference follows the active profile setpoint, not the holdback
    always_comb begin
        cif.pv = process_value_in;
        cif.alm_value = alarm_value_in;
        cif.alm_type = rsg_pkg::rsg_alm_t'(alarm_type_in);
        case (state_r)
            rsg_pkg::RSG_RAMP: cif.ref_val = sp_r;
            rsg_pkg::RSG_SOAK: cif.ref_val = tgt;
            default: cif.ref_val = working_setpoint_in;
        endcase
    end

    // Registered status and non-volatile image
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            setpoint_out <= '0;
            segment_out <= '0;
            ramping_out <= 1'b0;
            soaking_out <= 1'b0;
            hold_out <= 1'b0;
            alarm_out <= 1'b0;
            close_drive_out <= 1'b0;
            profile_done_out <= 1'b0;
            nv_seg_out <= '0;
            nv_soak_out <= 1'b0;
            nv_elapsed_out <= '0;
        end else begin
            case (state_r)
                rsg_pkg::RSG_RAMP: setpoint_out <= sp_r;
                rsg_pkg::RSG_SOAK: setpoint_out <= tgt;
                default: setpoint_out <= working_setpoint_in;
            endcase
            segment_out <= seg_r;
            ramping_out <= state_r == rsg_pkg::RSG_RAMP && !cut;
            soaking_out <= state_r == rsg_pkg::RSG_SOAK;
            hold_out <= (state_r == rsg_pkg::RSG_RAMP && ramp_hold)
                        || (state_r == rsg_pkg::RSG_SOAK && !soak_in);
            alarm_out <= cif.alarm;
            close_drive_out <= enable_in && state_r == rsg_pkg::RSG_END && output_off_in;
            profile_done_out <= end_go;
            nv_seg_out <= seg_r;
            nv_soak_out <= state_r == rsg_pkg::RSG_SOAK || elapsed_r != '0;
            nv_elapsed_out <= elapsed_r;
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_end_entry;
        state_r != rsg_pkg::RSG_END ##1 state_r == rsg_pkg::RSG_END;
    endsequence

    sequence s_soak_exit;
        state_r == rsg_pkg::RSG_SOAK && soak_done && seg_r != LAST_SEG && enable_in
            && !start_go;
    endsequence

    seg_order_a: assert property (
        s_soak_exit |=> state_r == rsg_pkg::RSG_RAMP && seg_r == $past(seg_r) + 2'h1)
        else $error("segment order broken");
    servo_start_a: assert property (
        start_go |=> sp_r == $past(process_value_in))
        else $error("ramp did not start at process value");
    ramp_freeze_a: assert property (
        (state_r == rsg_pkg::RSG_RAMP && ramp_hold && enable_in && !start_go) |=> $stable(sp_r))
        else $error("setpoint moved during ramp hold");
    soak_freeze_a: assert property (
        (state_r == rsg_pkg::RSG_SOAK && !soak_in && !soak_done && enable_in && !start_go)
        |=> $stable(elapsed_r))
        else $error("soak timer ran outside band");
    close_drive_a: assert property (
        (s_end_entry ##0 (output_off_in && enable_in)[*2]) |=> close_drive_out)
        else $error("close drive not held at end");
    eop_pulse_a: assert property (
        (end_go && alarm_eop_in) |=> third_output_out [*8])
        else $error("end-of-profile pulse too short");
    cut_end_a: assert property (
        (state_r == rsg_pkg::RSG_RAMP && cut && enable_in && !start_go)
        |=> state_r == rsg_pkg::RSG_END && profile_done_out)
        else $error("cut segment did not end profile");
    ramp_dir_a: assert property (
        (state_r == rsg_pkg::RSG_RAMP && tgt > sp_r && rate != '0 && enable_in && !start_go
         && $stable(seg_r)) |=> sp_r >= $past(sp_r))
        else $error("rising ramp stepped down");
    resume_soak_a: assert property (
        (resume_go && nv_soak_in) |=> elapsed_r == $past(nv_elapsed_in)
            && state_r == rsg_pkg::RSG_RAMP)
        else $error("soak progress lost on resume");
endmodule : rsg_profile

`default_nettype wire

// >>> src/rsg_pkg.sv
// Shared constants and types for the ramp/soak profile generator.
// Assumes a single 10 MHz controller clock.
`default_nettype none

package rsg_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned SEC_CYCLES = TICK_S * CLK_HZ;
    localparam int unsigned SEC_PER_MIN = 60;
    localparam int unsigned EOP_PULSE_S = 10;
    localparam int unsigned VAL_W = 16;
    localparam int unsigned SEG_N = 4;

    typedef enum logic [2:0] {
        RSG_IDLE = 3'h0,
        RSG_RAMP = 3'h1,
        RSG_SOAK = 3'h2,
        RSG_END = 3'h3
    } rsg_state_t;

    typedef enum logic [1:0] {
        RSG_ALM_NONE = 2'h0,
        RSG_ALM_DEV = 2'h1,
        RSG_ALM_WIN = 2'h2
    } rsg_alm_t;
endpackage : rsg_pkg

`default_nettype wire

// >>> src/rsg_core_if.sv
// Carrier between the profile core, its time base and its alarm unit.
// Assumes all parties share core_clk_in.
`default_nettype none

interface rsg_core_if #(parameter int W = 16);
    logic sec_tick;
    logic signed [W-1:0] pv;
    logic signed [W-1:0] ref_val;
    logic signed [W-1:0] alm_value;
    rsg_pkg::rsg_alm_t alm_type;
    logic alarm;

    modport tbase (output sec_tick);
    modport alm (input pv, input ref_val, input alm_value, input alm_type, output alarm);
    modport core (input sec_tick, input alarm,
                  output pv, output ref_val, output alm_value, output alm_type);
endinterface : rsg_core_if

`default_nettype wire

// >>> src/rsg_timebase.sv
// One-second tick divider for ramp and soak timing.
// Assumes one clock; tick is a one-cycle enable.
`default_nettype none

module rsg_timebase #(
    parameter int unsigned SEC_CYCLES = rsg_pkg::SEC_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    rsg_core_if.tbase tb
);
    localparam int CW = $clog2(SEC_CYCLES + 1);
    logic [CW-1:0] cnt_r;
    logic tick_r;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (cnt_r == CW'(SEC_CYCLES - 1)) begin
            cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + CW'(1'b1);
            tick_r <= 1'b0;
        end
    end

    assign tb.sec_tick = tick_r;

    tick_period_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        tick_r |-> cnt_r == '0) else $error("tick off its period");
endmodule : rsg_timebase

`default_nettype wire

// >>> src/rsg_alarm.sv
// Relative deviation and window alarm against the active profile reference.
// Assumes reference and process value are signed, same width.
`default_nettype none

module rsg_alarm #(
    parameter int W = 16
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    rsg_core_if.alm al
);
    logic signed [W:0] diff;
    logic [W:0] mag;
    logic alarm_r;
    logic alarm_nxt;

    always_comb begin
        diff = $signed({al.pv[W-1], al.pv}) - $signed({al.ref_val[W-1], al.ref_val});
        mag = diff[W] ? (W+1)'(-diff) : diff;
        alarm_nxt = 1'b0;
        case (al.alm_type)
            rsg_pkg::RSG_ALM_DEV: begin
                if (!al.alm_value[W-1])
                    alarm_nxt = diff >= $signed({1'b0, al.alm_value});
                else
                    alarm_nxt = -diff >= -$signed({1'b1, al.alm_value});
            end
            rsg_pkg::RSG_ALM_WIN: alarm_nxt = mag >= {1'b0, al.alm_value};
            default: alarm_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) alarm_r <= 1'b0;
        else alarm_r <= alarm_nxt;
    end

    assign al.alarm = alarm_r;

    win_alarm_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (al.alm_type == rsg_pkg::RSG_ALM_WIN && mag >= {1'b0, al.alm_value}) |=> alarm_r)
        else $error("window alarm missed");
    dev_pos_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (al.alm_type == rsg_pkg::RSG_ALM_DEV && !al.alm_value[W-1]
         && diff < $signed({1'b0, al.alm_value})) |=> !alarm_r)
        else $error("positive deviation alarm false");
    none_alarm_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        al.alm_type == rsg_pkg::RSG_ALM_NONE |=> !alarm_r)
        else $error("alarm raised while unselected");
endmodule : rsg_alarm

`default_nettype wire

// >>> dv/rsg_pv_model.sv
// Plant and measurement model standing behind process_value_in.
// Assumes one clock; the plant follows the setpoint one cycle late.
`default_nettype none

module rsg_pv_model #(
    parameter int W = 16
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic track_in,
    input wire logic signed [W-1:0] setpoint_in,
    input wire logic signed [W-1:0] offset_in,
    output logic signed [W-1:0] process_value_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic signed [W-1:0] plant_r;
    // Frozen plant lets the bench provoke holdback
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            plant_r <= 16'sh0064;
        end else if (track_in) begin
            plant_r <= setpoint_in;
        end
    end
    assign process_value_out = plant_r + offset_in;
endmodule : rsg_pv_model

`default_nettype wire

// >>> dv/ramp_soak_profile_generator_tb.sv
// Self-checking bench for the ramp/soak profile generator.
// Assumes rsg_pkg, the design sources and rsg_pv_model are compiled first.
`default_nettype none

module ramp_soak_profile_generator_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int W = rsg_pkg::VAL_W;
    logic core_clk_in = 0, rst_in = 1, enable_in = 0, start_in = 0, resume_in = 0;
    logic [1:0] nv_seg_in = 0, alarm_type_in = 0, segment_out, nv_seg_out;
    logic nv_soak_in = 0, output_off_in = 1, alarm_eop_in = 1, track = 0;
    logic [W+5:0] nv_elapsed_in = 0, nv_elapsed_out;
    logic signed [W-1:0] working_setpoint_in = 16'sh00c8, alarm_value_in = 0;
    logic signed [W-1:0] offset = 0, pv, setpoint_out;
    logic [3:0][W-1:0] ramp_rate_in = {16'h0258, 16'h003c, 16'h0258, 16'h003c};
    logic [3:0][W-1:0] target_in = {16'h008c, 16'h0096, 16'h006e, 16'h0082};
    logic [3:0][W-1:0] soak_min_in = {16'h0000, 16'h0000, 16'h0001, 16'h0001};
    logic [W-1:0] ramp_band_in = 0, soak_band_in = 16'h0005;
    logic ramping_out, soaking_out, hold_out, alarm_out, close_drive_out;
    logic third_output_out, profile_done_out, nv_soak_out;
    int n_mismatch = 0, n_compared = 0, seed = 71849, seg_skip = 0;
    logic [1:0] seg_last = 0;

    // Short second keeps whole soaks to a few hundred cycles
    rsg_profile #(.W(W), .SEC_CYCLES(4)) dut_u (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .enable_in(enable_in),
        .start_in(start_in), .resume_in(resume_in), .nv_seg_in(nv_seg_in),
        .nv_soak_in(nv_soak_in), .nv_elapsed_in(nv_elapsed_in), .process_value_in(pv),
        .working_setpoint_in(working_setpoint_in), .ramp_rate_in(ramp_rate_in),
        .target_in(target_in), .soak_min_in(soak_min_in), .ramp_band_in(ramp_band_in),
        .soak_band_in(soak_band_in), .alarm_type_in(alarm_type_in),
        .alarm_value_in(alarm_value_in), .output_off_in(output_off_in),
        .alarm_eop_in(alarm_eop_in), .setpoint_out(setpoint_out), .segment_out(segment_out),
        .ramping_out(ramping_out), .soaking_out(soaking_out), .hold_out(hold_out),
        .alarm_out(alarm_out), .close_drive_out(close_drive_out),
        .third_output_out(third_output_out), .profile_done_out(profile_done_out),
        .nv_seg_out(nv_seg_out), .nv_soak_out(nv_soak_out), .nv_elapsed_out(nv_elapsed_out)
    );
    rsg_pv_model #(.W(W)) pv_u (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .track_in(track),
        .setpoint_in(setpoint_out), .offset_in(offset), .process_value_out(pv)
    );

    initial begin
        forever #50 core_clk_in = ~core_clk_in;
    end

    // Segments may only stay or advance by one
    always @(negedge core_clk_in) begin
        if (ramping_out === 1'b1 || soaking_out === 1'b1) begin
            if (segment_out !== seg_last && segment_out !== seg_last + 2'h1) seg_skip++;
            seg_last = segment_out;
        end
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk_val(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk_val

    task automatic chk_rng(input int lo, input int hi, input logic signed [31:0] got);
        n_compared++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: expected %h..%h got %h", $time, lo, hi, got);
        end
    endtask : chk_rng

    function automatic logic alarm_exp(input int t, input int v, input int d);
        case (t)
            1: return (v > 0) ? (d >= v) : (d <= v);
            2: return (d >= v) || (d <= -v);
            default: return 1'b0;
        endcase
    endfunction : alarm_exp

    // Waits for ramping (0), soaking (1) or end pulse (2); n is the cycle count
    task automatic wait_flag(input int k, input int lim, output int n);
        logic f;
        n = 0;
        f = 1'b0;
        while (f !== 1'b1) begin
            @(negedge core_clk_in);
            f = (k == 0) ? ramping_out : (k == 1) ? soaking_out : profile_done_out;
            n++;
            if (n > lim) begin
                n_mismatch++;
                end_sim();
            end
        end
    endtask : wait_flag

    task automatic pulse(input bit res);
        @(posedge core_clk_in);
        start_in <= !res;
        resume_in <= res;
        @(posedge core_clk_in);
        start_in <= 1'b0;
        resume_in <= 1'b0;
    endtask : pulse

    // Soak of one minute with ten held seconds; sgn picks the far side of the band
    task automatic run_soak(input int sgn, input int tgt);
        int n;
        chk_val(tgt, setpoint_out);
        @(posedge core_clk_in) offset <= W'(sgn * 3);
        repeat (8) @(negedge core_clk_in);
        chk_val(0, hold_out);
        @(posedge core_clk_in) offset <= W'(sgn * 20);
        repeat (8) @(negedge core_clk_in);
        chk_val(1, hold_out);
        repeat (32) @(posedge core_clk_in);
        offset <= 0;
        wait_flag(0, 400, n);
        chk_rng(268, 296, n + 49);
    endtask : run_soak

    initial begin
        int n;
        int s;
        int a_t;
        int a_v;
        int o;
        repeat (16) @(posedge core_clk_in);
        chk_val(0, {ramping_out, soaking_out, profile_done_out, close_drive_out});
        rst_in <= 1'b0;
        enable_in <= 1'b1;
        pulse(0);
        wait_flag(0, 8, n);
        chk_rng(100, 101, setpoint_out);
        @(posedge core_clk_in) track <= 1'b1;
        wait_flag(1, 300, n);
        chk_rng(110, 132, n);
        run_soak(-1, 130);
        wait_flag(1, 100, n);
        run_soak(1, 110);
        @(posedge core_clk_in);
        ramp_band_in <= 16'h0005;
        track <= 1'b0;
        repeat (40) @(negedge core_clk_in);
        s = setpoint_out;
        chk_val(1, hold_out);
        repeat (20) @(negedge core_clk_in);
        chk_val(s, setpoint_out);
        @(posedge core_clk_in) track <= 1'b1;
        wait_flag(2, 600, n);
        repeat (2) @(negedge core_clk_in);
        chk_val(1, close_drive_out);
        n = 0;
        while (third_output_out === 1'b1 && n < 100) begin
            @(negedge core_clk_in);
            n++;
        end
        chk_rng(34, 41, n);
        chk_val(3, seg_last);
        chk_val(0, seg_skip);
        chk_val(1, close_drive_out);
        @(posedge core_clk_in) enable_in <= 1'b0;
        repeat (3) @(negedge core_clk_in);
        chk_val(0, close_drive_out);
        // Second segment cut off: end right after the first ramp
        @(posedge core_clk_in);
        enable_in <= 1'b1;
        output_off_in <= 1'b0;
        alarm_eop_in <= 1'b0;
        ramp_rate_in[0] <= 16'h0258;
        target_in[0] <= 16'h00b4;
        soak_min_in[0] <= 16'h0000;
        ramp_rate_in[1] <= 16'h0000;
        soak_min_in[1] <= 16'h0000;
        seg_last = 0;
        pulse(0);
        wait_flag(2, 80, n);
        repeat (3) @(negedge core_clk_in);
        chk_val(200, setpoint_out);
        chk_val(0, close_drive_out);
        chk_val(0, seg_last);
        // Alarms in a long soak, both hold bands off
        @(posedge core_clk_in);
        ramp_band_in <= 16'h0000;
        soak_band_in <= 16'h0000;
        soak_min_in[0] <= 16'h0005;
        pulse(0);
        wait_flag(1, 100, n);
        for (int i = 0; i < 40; i++) begin
            a_t = $random(seed) & 3;
            a_v = $random(seed) % 30;
            o = $random(seed) % 40;
            if (a_v == 0) a_v = 7;
            if (i < 8) begin
                a_t = i % 4;
                o = (i < 4) ? a_v : -a_v;
            end
            if (a_t == 2 && a_v < 0) a_v = -a_v;
            @(posedge core_clk_in);
            alarm_type_in <= a_t[1:0];
            alarm_value_in <= a_v[W-1:0];
            offset <= o[W-1:0];
            repeat (4) @(negedge core_clk_in);
            chk_val(alarm_exp(a_t, a_v, o), alarm_out);
            chk_val(0, hold_out);
        end
        // Power returns inside soak of segment 2 with 40 s already spent
        @(posedge core_clk_in);
        enable_in <= 1'b0;
        offset <= 0;
        repeat (4) @(posedge core_clk_in);
        track <= 1'b0;
        enable_in <= 1'b1;
        nv_seg_in <= 2'h2;
        nv_soak_in <= 1'b1;
        nv_elapsed_in <= 22'h00_0028;
        ramp_rate_in[2] <= 16'h0258;
        soak_min_in[2] <= 16'h0001;
        seg_last = 2;
        pulse(1);
        wait_flag(0, 8, n);
        chk_val(2, segment_out);
        chk_rng(190, 200, setpoint_out);
        @(posedge core_clk_in) track <= 1'b1;
        wait_flag(1, 200, n);
        chk_val({2'h2, 1'b1}, {nv_seg_out, nv_soak_out});
        chk_rng(40, 41, nv_elapsed_out);
        wait_flag(0, 200, n);
        chk_rng(72, 88, n);
        wait_flag(2, 200, n);
        chk_val(0, seg_skip);
        end_sim();
    end
endmodule : ramp_soak_profile_generator_tb

`default_nettype wire
